// [logic/smswc_pkg.sv]
// Shared constants and types for the switch monitor mode control
package smswc_pkg;
  localparam int NSW           = 22;
  localparam int NSP           = 8;
  localparam int SP_LSB        = 14;
  localparam int CLK_PERIOD_NS = 40;
  // Timer grain of 1 ms
  localparam int TICK_NS       = 1_000_000;
  localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam int SCAN_WIN_NS   = 125_000;
  localparam int SCAN_WIN_CYC  = (SCAN_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WET_MS        = 20;
  localparam int FRAME_LEN     = 24;

  localparam logic [11:0] INT_BASE_MS = 12'h020;
  localparam logic [11:0] SCAN_BASE_MS = 12'h001;
  localparam logic [2:0]  INT_OFF     = 3'h7;
  localparam logic [2:0]  SCAN_OFF    = 3'h0;
  localparam logic [4:0]  WET_INIT    = 5'(WET_MS);
  localparam logic [4:0]  FRAME_BITS  = 5'(FRAME_LEN);
  localparam logic [21:0] CFG_POR     = 22'h3fffff;
  localparam logic [7:0]  POL_POR     = 8'hff;

  localparam logic [7:0] CMD_POL_SP   = 8'h01;
  localparam logic [7:0] CMD_WAKE_SP  = 8'h02;
  localparam logic [7:0] CMD_WAKE_SG  = 8'h03;
  localparam logic [7:0] CMD_METAL_SP = 8'h04;
  localparam logic [7:0] CMD_METAL_SG = 8'h05;
  localparam logic [7:0] CMD_WTMR_SP  = 8'h07;
  localparam logic [7:0] CMD_WTMR_SG  = 8'h08;
  localparam logic [7:0] CMD_TRI_SP   = 8'h09;
  localparam logic [7:0] CMD_TRI_SG   = 8'h0a;
  localparam logic [7:0] CMD_SLEEP    = 8'h0c;
  localparam logic [7:0] CMD_RESET    = 8'h7f;

  typedef enum logic [1:0] {MODE_NORMAL, MODE_SLEEP, MODE_SCAN} smswc_mode_e;

  // Control pins that cross into the clock domain together
  typedef struct packed {
    logic sclk;
    logic cs_b;
    logic mosi;
    logic rouse_b;
    logic alert_in;
    logic hot;
    logic vdd_ok;
  } smswc_ctl_s;

  // Idle pin levels, so that leaving reset shows no false edge
  localparam smswc_ctl_s CTL_IDLE = '{sclk: 1'b0, cs_b: 1'b1, mosi: 1'b0, rouse_b: 1'b1,
                                      alert_in: 1'b1, hot: 1'b0, vdd_ok: 1'b1};
endpackage

// [logic/smswc_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module smswc_sync import smswc_pkg::*; #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Raw and filtered levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] f1;
    logic [W-1:0] f2;
    logic [W-1:0] f3;
    logic [W-1:0] lvl;
  } smswc_sync_s;

  smswc_sync_s s, next_s;
  logic [W-1:0] agree;

  // First stage feeds only the second
  assign agree = ~(s.f2 ^ s.f3);
  assign rise  = agree & s.f3 & ~s.lvl;
  assign fall  = agree & ~s.f3 & s.lvl;
  assign lvl   = s.lvl;

  always_comb begin
    next_s     = s;
    next_s.f1  = din;
    next_s.f2  = s.f1;
    next_s.f3  = s.f2;
    next_s.lvl = (agree & s.f3) | (~agree & s.lvl);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      // Reset to the idle level of the pin, else a false edge follows reset
      s <= {4{RST_VAL}};
    end else begin
      s <= next_s;
    end
  end
endmodule

// [logic/smswc_timer.sv]
// Millisecond period timer with automatic restart
`timescale 1ns/1ps
module smswc_timer import smswc_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Control
  input  wire logic        clear,
  input  wire logic        run,
  input  wire logic        tick,
  input  wire logic [11:0] limit,
  // Expiry pulse
  output logic             expired
);
  typedef struct packed {
    logic [11:0] cnt;
  } smswc_timer_s;

  smswc_timer_s s, next_s;

  assign expired = run && tick && (s.cnt == limit - 12'h001);

  always_comb begin
    next_s = s;
    if (clear) begin
      next_s.cnt = '0;
    end else if (expired) begin
      next_s.cnt = '0;
    end else if (run && tick) begin
      next_s.cnt = s.cnt + 12'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// [logic/smswc_top.sv]
// Switch monitor mode control: serial link, alert, sleep, scan, wetting, thermal
// Overview of operation
// (RULE1) Normal mode: each enabled contact change drives the alert line low.
// (RULE2) Metallic input with timer on gets high current for 20 ms after change.
// (RULE3) Alert stays low until the host reads status over the link.
// (RULE4) Change during chip select low keeps alert asserted past select rise.
// (RULE5) Host may mask alerts and poll; short pulses are then missed.
// (RULE6) Only a valid sleep command moves normal mode to sleep.
// (RULE7) Configuration is held unchanged through sleep.
// (RULE8) Sleep exits on change, timer, rouse fall, alert fall, select fall.
// (RULE9) Without logic supply, alert and select falls do not wake.
// (RULE10) Host discards the first response word after a select wake.
// (RULE11) Interrupt timer expiry in sleep raises alert and wakes.
// (RULE12) Interrupt period 32 ms doubling per code, code 7 disables.
// (RULE13) Scan period off at 0, 1 ms doubling per code to 64 ms.
// (RULE14) Scan expiry reactivates inputs for 125 us and samples them.
// (RULE15) Scan mismatch wakes device, raising alert when that input is enabled.
// (RULE16) Scan match restarts scan timer, inputs idle, sleep continues.
// (RULE17) Both sleep timers are held cleared in normal mode.
// (RULE18) Thermal supervision works in normal mode only.
// (RULE19) Overtemperature raises alert, drops high current, sets thermal flag.
// (RULE20) Thermal flag clears at select rise only once cool.
// (RULE21) Timer disabled input gets continuous wetting while closed.
// (RULE22) Response word shows open as 0 and closed as 1.
// (RULE23) Reset command returns all configuration to power-on values.
// (RULE24) Sleep frame: top byte 0x0c, bits 5:3 interrupt, 2:0 scan.
// (RULE25) Sleep timers start from zero at entry, from the internal clock.
`timescale 1ns/1ps
module smswc_top import smswc_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // Clock and reset
  input  wire logic             CLK,
  input  wire logic             RST_B,
  // Serial link
  input  wire logic             SCLK,
  input  wire logic             CS_B,
  input  wire logic             MOSI,
  output logic                  MISO,
  output logic                  MISO_OE,
  // Alert line, open drain
  input  wire logic             ALERT_IN,
  output logic                  ALERT_O,
  output logic                  ALERT_OE,
  // Wake and supply
  input  wire logic             ROUSE_B,
  input  wire logic             VDD_OK,
  input  wire logic             THERM_HOT,
  // Switch inputs, comparator says pin below threshold
  input  wire logic [NSW-1:0]   IN_LOW,
  // Current source control
  output logic [NSW-1:0]        SRC_ON,
  output logic [NSW-1:0]        SRC_HIGH,
  output logic                  SLEEPING
);
  typedef struct packed {
    smswc_mode_e         mode;
    logic [NSW-1:0]      wake;
    logic [NSW-1:0]      metal;
    logic [NSW-1:0]      wtmr;
    logic [NSW-1:0]      tri_st;
    logic [NSP-1:0]      pol;
    logic [2:0]          int_sel;
    logic [2:0]          scan_sel;
    logic [NSW-1:0]      last;
    logic [NSW-1:0]      snap;
    logic                int_pend;
    logic                chg_frm;
    logic                therm;
    logic [23:0]         rx;
    logic [23:0]         tx;
    logic [4:0]          bits;
    logic [14:0]         pre;
    logic [11:0]         win;
    logic [NSW-1:0][4:0] wet;
    logic [NSW-1:0]      src_on;
    logic [NSW-1:0]      src_high;
    logic                miso;
  } smswc_state_s;

  smswc_state_s s, next_s;
  smswc_ctl_s   ctl_raw, c_lvl, c_rise, c_fall;
  logic [NSW-1:0] low_lvl, closed, chg, diff, want;
  logic tick, int_exp, scan_exp, cs_rise, cs_fall, frame_ok, sleep_cmd;
  logic rouse_wake, alert_wake, cs_wake, any_wake, win_end;
  logic hot_now;

  assign ctl_raw = '{sclk: SCLK, cs_b: CS_B, mosi: MOSI, rouse_b: ROUSE_B,
                     alert_in: ALERT_IN, hot: THERM_HOT, vdd_ok: VDD_OK};

  // Idle reset levels keep a select edge from appearing right after reset
  smswc_sync #(.W($bits(smswc_ctl_s)), .RST_VAL(CTL_IDLE)) u_ctl_sync (
    .clk   (CLK),
    .rst_b (RST_B),
    .din   (ctl_raw),
    .lvl   (c_lvl),
    .rise  (c_rise),
    .fall  (c_fall)
  );

  smswc_sync #(.W(NSW)) u_sw_sync (
    .clk   (CLK),
    .rst_b (RST_B),
    .din   (IN_LOW),
    .lvl   (low_lvl),
    .rise  (),
    .fall  ()
  );

  // Ground-switched inputs read closed when low; battery-switched when high
  assign closed = {low_lvl[NSW-1:SP_LSB] ^ s.pol, low_lvl[SP_LSB-1:0]};
  assign chg    = closed ^ s.last;
  assign diff   = closed ^ s.snap;

  assign cs_rise   = c_rise.cs_b;
  assign cs_fall   = c_fall.cs_b;
  assign frame_ok  = cs_rise && (s.bits == FRAME_BITS);
  assign sleep_cmd = frame_ok && (s.rx[23:16] == CMD_SLEEP); // RULE24
  assign tick      = (s.pre == 15'(TICK_CYCLES - 1));
  assign win_end   = (s.win == 12'(SCAN_WIN_CYC - 1));

  // Supply-gated wake sources; rouse needs no logic supply
  assign rouse_wake = c_fall.rouse_b; // RULE8
  assign alert_wake = c_fall.alert_in && c_lvl.rouse_b && c_lvl.vdd_ok; // RULE9
  assign cs_wake    = cs_fall && c_lvl.vdd_ok; // RULE9
  assign any_wake   = rouse_wake || alert_wake || cs_wake;
  assign hot_now    = c_lvl.hot && (s.mode == MODE_NORMAL); // RULE18

  // Timers are cleared throughout normal mode
  // Run is gated too, so a stale count cannot fire in the first normal cycle
  smswc_timer u_int_tmr (
    .clk     (CLK),
    .rst_b   (RST_B),
    .clear   (s.mode == MODE_NORMAL), // RULE17
    .run     ((s.mode != MODE_NORMAL) && (s.int_sel != INT_OFF)), // RULE12 RULE17
    .tick    (tick),
    .limit   (INT_BASE_MS << s.int_sel), // RULE12
    .expired (int_exp)
  );

  smswc_timer u_scan_tmr (
    .clk     (CLK),
    .rst_b   (RST_B),
    .clear   (s.mode == MODE_NORMAL), // RULE17
    .run     ((s.mode == MODE_SLEEP) && (s.scan_sel != SCAN_OFF)), // RULE13
    .tick    (tick),
    .limit   (SCAN_BASE_MS << (s.scan_sel - 3'h1)), // RULE13
    .expired (scan_exp)
  );

  always_comb begin
    next_s = s;
    // Prescaler restarts at sleep entry so both timers begin at zero
    next_s.pre = tick ? '0 : s.pre + 15'h0001; // RULE25

    // Link: sample on rising clock edge, shift out on falling
    if (cs_fall) begin
      next_s.bits = '0;
      next_s.chg_frm = 1'b0;
      next_s.tx = {s.therm, s.int_pend, closed}; // RULE22
    end else if (!c_lvl.cs_b) begin
      if (c_rise.sclk && s.bits != FRAME_BITS) begin
        next_s.rx = {s.rx[22:0], c_lvl.mosi};
        next_s.bits = s.bits + 5'h01;
      end
      if (c_fall.sclk) begin
        next_s.tx = {s.tx[22:0], 1'b0};
      end
    end
    next_s.miso = next_s.tx[23];

    // Status read ends at select rise; a change inside the frame keeps the alert
    if (cs_rise && !s.chg_frm) begin
      next_s.int_pend = 1'b0; // RULE3
    end

    // Thermal flag clears only when cool
    if (cs_rise && !c_lvl.hot) begin
      next_s.therm = 1'b0; // RULE20
    end

    // Commands, accepted only from normal mode
    if (frame_ok && s.mode == MODE_NORMAL) begin // RULE7
      case (s.rx[23:16])
        CMD_POL_SP:   next_s.pol = s.rx[NSP-1:0];
        CMD_WAKE_SP:  next_s.wake[NSW-1:SP_LSB] = s.rx[NSP-1:0];
        CMD_WAKE_SG:  next_s.wake[SP_LSB-1:0] = s.rx[SP_LSB-1:0];
        CMD_METAL_SP: next_s.metal[NSW-1:SP_LSB] = s.rx[NSP-1:0];
        CMD_METAL_SG: next_s.metal[SP_LSB-1:0] = s.rx[SP_LSB-1:0];
        CMD_WTMR_SP:  next_s.wtmr[NSW-1:SP_LSB] = s.rx[NSP-1:0]; // RULE21
        CMD_WTMR_SG:  next_s.wtmr[SP_LSB-1:0] = s.rx[SP_LSB-1:0]; // RULE21
        CMD_TRI_SP:   next_s.tri_st[NSW-1:SP_LSB] = s.rx[NSP-1:0];
        CMD_TRI_SG:   next_s.tri_st[SP_LSB-1:0] = s.rx[SP_LSB-1:0];
        CMD_SLEEP: begin
          next_s.mode = MODE_SLEEP; // RULE6
          next_s.int_sel = s.rx[5:3]; // RULE24
          next_s.scan_sel = s.rx[2:0]; // RULE24
          next_s.snap = s.last;
          next_s.pre = '0; // RULE25
        end
        CMD_RESET: begin
          next_s.wake = CFG_POR; // RULE23
          next_s.metal = CFG_POR; // RULE23
          next_s.wtmr = CFG_POR; // RULE23
          next_s.tri_st = CFG_POR; // RULE23
          next_s.pol = POL_POR; // RULE23
        end
        default: next_s.mode = s.mode;
      endcase
    end

    // Per-input wetting timers run in ms ticks
    for (int i = 0; i < NSW; i++) begin
      if (s.mode == MODE_NORMAL && chg[i] && s.metal[i] && s.wtmr[i]) begin
        next_s.wet[i] = WET_INIT; // RULE2
      end else if (tick && s.wet[i] != '0) begin
        next_s.wet[i] = s.wet[i] - 5'h01; // RULE2
      end
    end

    case (s.mode)
      MODE_NORMAL: begin
        next_s.last = closed;
        if (|(chg & s.wake)) begin
          next_s.int_pend = 1'b1; // RULE1
          if (!c_lvl.cs_b) begin
            next_s.chg_frm = 1'b1; // RULE4
          end
        end
        if (c_lvl.hot && !s.therm) begin
          next_s.therm = 1'b1; // RULE18
          next_s.int_pend = 1'b1; // RULE19
        end
      end
      MODE_SLEEP: begin
        if (any_wake) begin
          next_s.mode = MODE_NORMAL; // RULE8
        end else if (int_exp) begin
          next_s.int_pend = 1'b1; // RULE11
          next_s.mode = MODE_NORMAL; // RULE11
        end else if (scan_exp) begin
          next_s.mode = MODE_SCAN; // RULE14
          next_s.win = '0;
        end
      end
      MODE_SCAN: begin
        next_s.win = s.win + 12'h001;
        if (any_wake) begin
          next_s.mode = MODE_NORMAL; // RULE8
        end else if (int_exp) begin
          next_s.int_pend = 1'b1; // RULE11
          next_s.mode = MODE_NORMAL; // RULE11
        end else if (win_end) begin
          if (|diff) begin
            next_s.mode = MODE_NORMAL; // RULE15
            // Set wins over a select clear in the same cycle
            next_s.int_pend = next_s.int_pend | (|(diff & s.wake)); // RULE15
          end else begin
            next_s.mode = MODE_SLEEP; // RULE16
          end
        end
      end
      default: next_s.mode = MODE_NORMAL;
    endcase

    // Sources run in normal mode and in the scan window only
    for (int i = 0; i < NSW; i++) begin
      want[i] = s.metal[i] && (s.wtmr[i] ? (s.wet[i] != '0) : closed[i]); // RULE21
    end
    next_s.src_on = (next_s.mode == MODE_SLEEP) ? '0 : ~s.tri_st; // RULE14
    // Overtemperature trades wetting strength for die safety
    next_s.src_high = next_s.src_on & want & {NSW{~hot_now}}; // RULE19 RULE20
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      s        <= '0;
      s.mode   <= MODE_NORMAL;
      s.wake   <= CFG_POR;
      s.metal  <= CFG_POR;
      s.wtmr   <= CFG_POR;
      s.tri_st <= CFG_POR;
      s.pol    <= POL_POR;
      s.int_sel  <= INT_OFF;
      s.scan_sel <= SCAN_OFF;
    end else begin
      s <= next_s;
    end
  end

  assign MISO     = s.miso;
  assign MISO_OE  = ~c_lvl.cs_b;
  assign ALERT_O  = 1'b0;
  assign ALERT_OE = s.int_pend;
  assign SRC_ON   = s.src_on;
  assign SRC_HIGH = s.src_high;
  assign SLEEPING = (s.mode != MODE_NORMAL);

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  sequence sleep_enter_q;
    s.mode == MODE_NORMAL ##1 s.mode == MODE_SLEEP;
  endsequence

  sequence scan_pass_q;
    s.mode == MODE_SCAN && win_end && !any_wake && !int_exp && diff == '0;
  endsequence

  sequence scan_miss_q;
    s.mode == MODE_SCAN && win_end && !any_wake && !int_exp && diff != '0;
  endsequence

  // All checks live in the main clock domain

  alert_on_change_a: assert property (s.mode == MODE_NORMAL && |(chg & s.wake) // RULE1
    |=> ALERT_OE) else $error("Enabled change did not raise alert");
  alert_release_a: assert property (ALERT_OE && cs_rise && !s.chg_frm && // RULE3
    s.mode == MODE_NORMAL && !(|(chg & s.wake)) && !c_lvl.hot |=> !ALERT_OE)
    else $error("Alert not released");
  frame_change_a: assert property (s.chg_frm && cs_rise |=> ALERT_OE [*2]) // RULE4
    else $error("Alert lost after in-frame change");
  sleep_entry_a: assert property (sleep_enter_q |-> $past(sleep_cmd, 1)) // RULE6
    else $error("Sleep entered without command");
  config_hold_a: assert property (s.mode != MODE_NORMAL |=> // RULE7
    $stable(s.wake) && $stable(s.metal) && $stable(s.tri_st)) else $error("Config moved");
  rouse_wake_a: assert property (s.mode == MODE_SLEEP && rouse_wake |=> // RULE8
    s.mode == MODE_NORMAL ##1 !SLEEPING) else $error("Rouse fall did not wake");
  scan_return_a: assert property (scan_pass_q |=> s.mode == MODE_SLEEP) // RULE16
    else $error("Clean scan left sleep");
  timer_idle_a: assert property (s.mode == MODE_NORMAL |-> !int_exp && !scan_exp) // RULE17
    else $error("Sleep timer ran in normal mode");
  thermal_sleep_a: assert property (s.mode == MODE_SLEEP && !s.therm // RULE18
    |=> !s.therm) else $error("Thermal flag set in sleep");
  thermal_force_a: assert property (hot_now |=> SRC_HIGH == '0) // RULE19
    else $error("High current kept while hot");
  thermal_cool_a: assert property (s.therm && cs_rise && !c_lvl.hot |=> !s.therm) // RULE20
    else $error("Thermal flag kept after cooling");
  int_wake_a: assert property (s.mode == MODE_SLEEP && !any_wake && int_exp // RULE11
    |=> s.mode == MODE_NORMAL && ALERT_OE) else $error("Timer expiry did not wake");
  scan_mismatch_a: assert property (scan_miss_q |=> s.mode == MODE_NORMAL) // RULE15
    else $error("Scan mismatch did not wake");
  cfg_reset_a: assert property (frame_ok && s.mode == MODE_NORMAL && // RULE23
    s.rx[23:16] == CMD_RESET |=> s.wake == CFG_POR && s.pol == POL_POR) else $error("Reset lost");
  wet_start_a: assert property (s.mode == MODE_NORMAL && chg[0] && s.metal[0] && // RULE2
    s.wtmr[0] |=> s.wet[0] == WET_INIT) else $error("Wetting timer not started");
endmodule

// [sim/smswc_host.sv]
// Host controller model on the far side of the serial link
`timescale 1ns/1ps
module smswc_host (
  // Clock
  input  wire logic   clk,
  // Serial link, clock stands low between frames
  output logic        sclk,
  output logic        cs_b,
  output logic        mosi,
  input  wire logic   miso,
  // Captured response word
  output logic [23:0] rx,
  output logic        rx_stb
);
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    mosi = 1'b0;
    rx = 24'h0;
    rx_stb = 1'b0;
  end
  // One frame of n bits, MSB first
  task automatic xfer(input logic [23:0] tx, input int n, input bit keep);
    @(negedge clk);
    cs_b = 1'b0;
    repeat (8) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      mosi = tx[23-i];
      repeat (4) @(negedge clk);
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      rx[23-i] = miso;
      sclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    cs_b = 1'b1;
    // Released line must not look as if it still held data
    mosi = ~mosi;
    // Word after a select wake is dropped, polling reads are kept
    rx_stb = keep;
    repeat (10) @(negedge clk);
    rx_stb = 1'b0;
  endtask
endmodule

// [sim/smswc_top_test.sv]
// Self-checking bench for the switch monitor mode control
`timescale 1ns/1ps
module smswc_top_test import smswc_pkg::*; ;
  localparam int TK = 10;
  logic           CLK = 1'b0;
  logic           RST_B = 1'b0;
  logic           ROUSE_B = 1'b1;
  logic           VDD_OK = 1'b1;
  logic           THERM_HOT = 1'b0;
  logic           ext = 1'b0;
  logic [NSW-1:0] IN_LOW = '0;
  logic [NSW-1:0] lo;
  logic [7:0]     pol;
  logic [47:0]    e;
  logic [47:0]    q[$];
  int             error_cnt = 0;
  int             cmp_count = 0;
  wire            SCLK, CS_B, MOSI, MISO, MISO_OE, ALERT_OE, ALERT_IN, rx_stb, SLEEPING;
  wire            ALERT_O;
  wire [NSW-1:0]  SRC_ON, SRC_HIGH;
  wire [23:0]     rx;
  // Shared alert wire with pull-up, ext lets the bench pull it too
  assign ALERT_IN = ~(ALERT_OE | ext);
  always #20 CLK = ~CLK;
  smswc_host i_host (.clk(CLK), .sclk(SCLK), .cs_b(CS_B), .mosi(MOSI), .miso(MISO),
    .rx(rx), .rx_stb(rx_stb));
  smswc_top #(.TICK_CYCLES(TK)) i_dut (.CLK(CLK), .RST_B(RST_B), .SCLK(SCLK), .CS_B(CS_B),
    .MOSI(MOSI), .MISO(MISO), .MISO_OE(MISO_OE), .ALERT_IN(ALERT_IN), .ALERT_O(ALERT_O),
    .ALERT_OE(ALERT_OE), .ROUSE_B(ROUSE_B), .VDD_OK(VDD_OK), .THERM_HOT(THERM_HOT),
    .IN_LOW(IN_LOW), .SRC_ON(SRC_ON), .SRC_HIGH(SRC_HIGH), .SLEEPING(SLEEPING));
  task automatic cyc(input int n);
    repeat (n) @(negedge CLK);
  endtask
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] ex);
    cmp_count++;
    if (seen !== ex) begin
      error_cnt++;
      $display("unexpected %s exp %h seen %h", nm, ex, seen);
    end
  endtask
  function automatic logic [23:0] st(input logic [1:0] f, input logic [7:0] p);
    return {f, lo[21:14] ^ p, lo[13:0]};
  endfunction
  task automatic rd(input logic [23:0] ex, input logic [23:0] mk);
    q.push_back({mk, ex});
    i_host.xfer(24'h0, 24, 1'b1);
  endtask
  task automatic close_out;
    if (error_cnt == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge rx_stb) begin
    e = q.pop_front();
    chk("status", rx & e[47:24], e[23:0] & e[47:24]);
  end
  initial begin
    #3_000_000;
    error_cnt++;
    close_out();
  end
  initial begin
    void'($urandom(32'hd512));
    cyc(20);
    chk("alert_oe", ALERT_OE, 24'h0);
    chk("src", {SRC_ON, MISO_OE, SLEEPING}, 24'h0);
    chk("alert_o", ALERT_O, 24'h0);
    RST_B = 1'b1;
    cyc(10);
    // Inputs active so the comparators and sources work
    i_host.xfer({CMD_TRI_SP, 16'h0}, 24, 1'b0);
    i_host.xfer({CMD_TRI_SG, 16'h0}, 24, 1'b0);
    chk("src_on", SRC_ON, 24'h3fffff);
    pol = 8'($urandom);
    lo = 22'($urandom);
    IN_LOW = lo;
    i_host.xfer({CMD_POL_SP, 8'h0, pol}, 24, 1'b0);
    i_host.xfer(24'h0, 24, 1'b0);
    rd(st(2'b00, pol), 24'hffffff);
    for (int i = 0; i < 2; i++) begin
      lo[0] = ~lo[0];
      IN_LOW = lo;
      cyc(8);
      chk("alert_oe", ALERT_OE, 24'h1);
      chk("src_high", SRC_HIGH[0], 24'h1);
      cyc(150);
      chk("src_high", SRC_HIGH[0], 24'h1);
      rd(st(2'b01, pol), 24'hffffff);
      chk("src_high", SRC_HIGH[0], 24'h0);
      chk("alert_oe", ALERT_OE, 24'h0);
    end
    fork
      rd(st(2'b00, pol), 24'hffffff);
      begin
        cyc(100);
        lo[1] = ~lo[1];
        IN_LOW = lo;
      end
    join
    chk("alert_oe", ALERT_OE, 24'h1);
    rd(st(2'b01, pol), 24'hffffff);
    // Timer off: closed contact keeps high current
    i_host.xfer({CMD_WTMR_SG, 16'h0}, 24, 1'b0);
    lo[0] = 1'b1;
    IN_LOW = lo;
    cyc(300);
    chk("src_high", SRC_HIGH[0], 24'h1);
    i_host.xfer(24'h0, 24, 1'b0);
    THERM_HOT = 1'b1;
    cyc(8);
    chk("alert_oe", ALERT_OE, 24'h1);
    chk("src_high", SRC_HIGH, 24'h0);
    rd(st(2'b11, pol), 24'hffffff);
    rd(st(2'b10, pol), 24'hffffff);
    THERM_HOT = 1'b0;
    cyc(8);
    chk("src_high", SRC_HIGH[0], 24'h1);
    rd(st(2'b10, pol), 24'hffffff);
    rd(st(2'b00, pol), 24'hffffff);
    i_host.xfer({CMD_SLEEP, 8'h0}, 16, 1'b0);
    i_host.xfer({8'h0d, 16'h0}, 24, 1'b0);
    cyc(10);
    chk("sleeping", SLEEPING, 24'h0);
    for (int i = 0; i < 2; i++) begin
      i_host.xfer({CMD_SLEEP, 10'h0, 3'(i), SCAN_OFF}, 24, 1'b0);
      cyc(10);
      chk("sleeping", SLEEPING, 24'h1);
      chk("src_on", SRC_ON, 24'h0);
      cyc(TK * (32 << i) - 40);
      chk("sleeping", SLEEPING, 24'h1);
      cyc(60);
      chk("woken", {SLEEPING, ALERT_OE}, 24'h1);
      i_host.xfer(24'h0, 24, 1'b0);
    end
    // Wake sources; slow timer and idle scans must not wake meanwhile
    for (int i = 0; i < 5; i++) begin
      i_host.xfer({CMD_SLEEP, 10'h0, 3'(i + 2), 3'(i + 3)}, 24, 1'b0);
      cyc(300);
      VDD_OK = (i != 3);
      case (i)
        0: ROUSE_B = 1'b0;
        1: ext = 1'b1;
        2, 3: i_host.xfer(24'h0, 24, 1'b0);
        default: THERM_HOT = 1'b1;
      endcase
      cyc(10);
      chk("sleeping", SLEEPING, 24'(i > 2));
      chk("alert_oe", ALERT_OE & (i == 4), 24'h0);
      ROUSE_B = 1'b1;
      ext = 1'b0;
      VDD_OK = 1'b1;
      THERM_HOT = 1'b0;
      i_host.xfer(24'h0, 24, 1'b0);
    end
    i_host.xfer({CMD_SLEEP, 10'h0, INT_OFF, 3'h1}, 24, 1'b0);
    cyc(8000);
    chk("sleeping", SLEEPING, 24'h1);
    lo[5] = ~lo[5];
    IN_LOW = lo;
    cyc(6500);
    chk("woken", {SLEEPING, ALERT_OE}, 24'h1);
    rd(st(2'b01, pol), 24'hffffff);
    i_host.xfer({CMD_RESET, 16'h0}, 24, 1'b0);
    rd(st({1'b0, pol != 8'hff}, 8'hff), 24'hffffff);
    close_out();
  end
endmodule
